/* core/rpc_pkg.sv */
// package of the region protection configuration block
// shared by the top module and the per-region matcher
package rpc_pkg;
  localparam int NUM_REGIONS = 8;
  // register byte addresses
  localparam logic [31:0] ADDR_CAPS = 32'hE000ED90;
  localparam logic [31:0] ADDR_CTRL = 32'hE000ED94;
  localparam logic [31:0] ADDR_SEL = 32'hE000ED98;
  localparam logic [31:0] ADDR_BASE = 32'hE000ED9C;
  localparam logic [31:0] ADDR_ATTR = 32'hE000EDA0;
  localparam logic [31:0] ADDR_BASE_A1 = 32'hE000EDA4;
  localparam logic [31:0] ADDR_ATTR_A1 = 32'hE000EDA8;
  localparam logic [31:0] ADDR_BASE_A2 = 32'hE000EDAC;
  localparam logic [31:0] ADDR_ATTR_A2 = 32'hE000EDB0;
  localparam logic [31:0] ADDR_BASE_A3 = 32'hE000EDB4;
  localparam logic [31:0] ADDR_ATTR_A3 = 32'hE000EDB8;
  // capabilities fields
  localparam logic [7:0] CAPS_INSTR_REGIONS = 8'h00;
  localparam logic [7:0] CAPS_DATA_REGIONS = 8'h08;
  localparam logic CAPS_SEPARATE = 1'b0;
  // control bits
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_HP_PROTECT_BIT = 1;
  localparam int CTRL_BG_ENABLE_BIT = 2;
  // base register fields
  localparam int BASE_VALID_BIT = 4;
  localparam int BASE_ADDR_LSB = 5;
  // attribute fields
  localparam int ATTR_ENABLE_BIT = 0;
  localparam int ATTR_SIZE_LSB = 1;
  localparam int ATTR_SRD_LSB = 8;
  localparam int ATTR_AP_LSB = 24;
  localparam int ATTR_XN_BIT = 28;
  localparam logic [31:0] ATTR_WMASK = 32'h173FFF3F;
  localparam logic [4:0] SIZE_MIN = 5'h04;
  localparam logic [4:0] SIZE_FULL = 5'h1F;
  // system control space and vector table windows
  localparam logic [31:0] SCS_BASE = 32'hE000E000;
  localparam logic [31:0] SCS_MASK = 32'hFFFFF000;
  localparam logic [31:0] VTAB_LIMIT = 32'h00000400;
  localparam logic [31:0] RESET_VALUE = 32'h00000000;
  typedef enum logic [1:0] {
    RPC_IDLE,
    RPC_ACCESS
  } rpc_bus_state_t;
endpackage

/* core/rpc_region_match.sv */
// one region comparator: decides hit and its permission outcome
// assumes base and attribute words straight from the register file
`timescale 1ns/1ns
module rpc_region_match (
  input wire logic [31:0] base,
  input wire logic [31:0] attr,
  input wire logic [31:0] addr,
  input wire logic priv,
  input wire logic write,
  input wire logic fetch,
  output logic hit,
  output logic allow
);
  import rpc_pkg::*;
  logic [4:0] size;
  logic [2:0] ap;
  logic [31:0] mask;
  logic [2:0] sub;
  logic sub_off;
  logic perm;
  always_comb begin
    size = attr[ATTR_SIZE_LSB +: 5];
    ap = attr[ATTR_AP_LSB +: 3];
    // region spans 2^(size+1) bytes; full size ignores the base
    mask = (size == SIZE_FULL) ? 32'h00000000 : (32'hFFFFFFFF << (size + 5'h01));
    // subregions below 256 bytes are not supported
    // full size still splits the map in eighths by the top address bits
    sub = (size >= 5'h07) ? 3'((addr >> (size - 5'h02)) & 32'h7) : 3'h0;
    sub_off = (size >= 5'h07) && attr[ATTR_SRD_LSB + 32'(sub)];
    hit = attr[ATTR_ENABLE_BIT] && (size >= SIZE_MIN) && !sub_off &&
          ((addr & mask) == (base & mask));
    case (ap)
      3'h1: perm = priv;
      3'h2: perm = priv || !write;
      3'h3: perm = 1'b1;
      3'h5: perm = priv && !write;
      3'h6, 3'h7: perm = !write;
      default: perm = 1'b0;
    endcase
    allow = perm && !(fetch && attr[ATTR_XN_BIT]);
  end
endmodule

/* core/rpc_top.sv */
// region protection configuration: apb registers and access check
// assumes privileged apb masters (pprot[0]) and a core giving one access per cycle
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module rpc_top #(
  parameter int REGIONS = rpc_pkg::NUM_REGIONS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_priv,
  input wire logic acc_write,
  input wire logic acc_fetch,
  input wire logic acc_high_prio,
  output logic acc_done,
  output logic memory_management_fault,
  output logic acc_execute_never,
  output logic acc_strongly_ordered
);
  import rpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    rpc_bus_state_t bus_state;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] ctrl;
    logic [7:0] sel;
    logic [REGIONS-1:0][31:0] base;
    logic [REGIONS-1:0][31:0] attr;
    logic acc_done;
    logic fault;
    logic xn;
    logic so;
  } rpc_state_t;

  rpc_state_t state_reg;
  rpc_state_t state_next;

  logic [REGIONS-1:0] hit;
  logic [REGIONS-1:0] allow;

  ////////////////////////////////////////////////////////////////////////////
  // one comparator per region
  genvar g;
  generate
    for (g = 0; g < REGIONS; g++) begin : gen_region
      rpc_region_match u_match (
        .base(state_reg.base[g]),
        .attr(state_reg.attr[g]),
        .addr(acc_addr),
        .priv(acc_priv),
        .write(acc_write),
        .fetch(acc_fetch),
        .hit(hit[g]),
        .allow(allow[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] idx;
  logic is_base;
  logic is_attr;
  logic known;
  logic any_hit;
  logic win_allow;
  logic checks_on;
  logic in_scs;
  logic in_vtab;
  logic ok;
  logic [2:0] tgt;

  always_comb begin
    state_next = state_reg;
    idx = state_reg.sel[2:0];
    tgt = idx;
    is_base = (paddr == ADDR_BASE) || (paddr == ADDR_BASE_A1) ||
              (paddr == ADDR_BASE_A2) || (paddr == ADDR_BASE_A3);
    is_attr = (paddr == ADDR_ATTR) || (paddr == ADDR_ATTR_A1) ||
              (paddr == ADDR_ATTR_A2) || (paddr == ADDR_ATTR_A3);
    known = is_base || is_attr || (paddr == ADDR_CAPS) || (paddr == ADDR_CTRL) ||
            (paddr == ADDR_SEL);

    // apb slave: setup, then one access cycle with pready
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    case (state_reg.bus_state)
      RPC_IDLE: begin
        if (psel && !penable) begin
          state_next.bus_state = RPC_ACCESS;
          state_next.pready = 1'b1;
          state_next.prdata = 32'h00000000;
          // unprivileged or unmapped accesses are refused with an error
          if (!pprot[0] || !known) begin
            state_next.pslverr = 1'b1;
          end else if (pwrite) begin
            if (paddr == ADDR_CTRL) begin
              state_next.ctrl = pwdata[2:0];
            end else if (paddr == ADDR_SEL) begin
              state_next.sel = pwdata[7:0];
            end else if (is_base) begin
              if (pwdata[BASE_VALID_BIT]) begin
                state_next.sel = {4'h0, pwdata[3:0]};
                tgt = pwdata[2:0];
              end
              // region field ignored when valid is clear
              state_next.base[tgt] = {pwdata[31:BASE_ADDR_LSB], 5'h00};
            end else if (is_attr) begin
              state_next.attr[idx] = pwdata & ATTR_WMASK;
            end
          end else begin
            if (paddr == ADDR_CAPS) begin
              state_next.prdata = {8'h00, CAPS_INSTR_REGIONS, CAPS_DATA_REGIONS,
                                   7'h00, CAPS_SEPARATE};
            end else if (paddr == ADDR_CTRL) begin
              state_next.prdata = {29'h0, state_reg.ctrl};
            end else if (paddr == ADDR_SEL) begin
              state_next.prdata = {24'h0, state_reg.sel};
            end else if (is_base) begin
              state_next.prdata = {state_reg.base[idx][31:BASE_ADDR_LSB], 1'b0,
                                   state_reg.sel[3:0]};
            end else begin
              state_next.prdata = state_reg.attr[idx];
            end
          end
        end
      end
      RPC_ACCESS: begin
        state_next.bus_state = RPC_IDLE;
      end
      default: begin
        state_next.bus_state = RPC_IDLE;
      end
    endcase

    // access check, answered one cycle after the request
    any_hit = 1'b0;
    win_allow = 1'b0;
    for (int i = 0; i < REGIONS; i++) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        win_allow = allow[i];
      end
    end
    in_scs = (acc_addr & SCS_MASK) == SCS_BASE;
    in_vtab = acc_addr < VTAB_LIMIT;
    // enable low means default map; background bit then has no effect
    checks_on = state_reg.ctrl[CTRL_ENABLE_BIT] &&
                !(acc_high_prio && !state_reg.ctrl[CTRL_HP_PROTECT_BIT]);
    if (!checks_on) begin
      ok = 1'b1;
    end else if (in_scs || in_vtab) begin
      ok = 1'b1;
    end else if (any_hit) begin
      ok = win_allow;
    end else begin
      ok = state_reg.ctrl[CTRL_BG_ENABLE_BIT] && acc_priv;
    end
    state_next.acc_done = acc_valid;
    state_next.fault = acc_valid && !ok;
    state_next.xn = acc_valid && in_scs;
    state_next.so = acc_valid && in_scs;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign acc_done = state_reg.acc_done;
  assign memory_management_fault = state_reg.fault;
  assign acc_execute_never = state_reg.xn;
  assign acc_strongly_ordered = state_reg.so;
endmodule

/* tb/rpc_core_model.sv */
// core side: issues one checked access, returns the verdict
// expects the answer one cycle after the request edge
`timescale 1ns/1ns
module rpc_core_model (
  input wire logic pclk,
  input wire logic acc_done,
  input wire logic memory_management_fault,
  input wire logic acc_execute_never,
  input wire logic acc_strongly_ordered,
  output logic acc_valid,
  output logic [31:0] acc_addr,
  output logic acc_priv,
  output logic acc_write,
  output logic acc_fetch,
  output logic acc_high_prio
);
  initial begin
    {acc_valid, acc_priv, acc_write, acc_fetch, acc_high_prio} = 5'h00;
    acc_addr = 32'h0;
  end
  task automatic issue(input logic [31:0] a, input logic p, h, w, fe,
                       output logic f, x, s);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_priv <= p;
    acc_high_prio <= h;
    acc_write <= w;
    acc_fetch <= fe;
    @(posedge pclk);
    acc_valid <= 1'b0;
    acc_write <= 1'b0;
    acc_fetch <= 1'b0;
    // idle address flips so a stale value never looks valid
    acc_addr <= ~a;
    @(negedge pclk);
    f = acc_done === 1'b1 ? memory_management_fault : 1'bx;
    x = acc_execute_never;
    s = acc_strongly_ordered;
  endtask
endmodule

/* tb/rpc_top_props.sv */
// concurrent checks on the rpc_top ports
// bound into every rpc_top instance, one clock domain
`timescale 1ns/1ns
module rpc_top_props
  import rpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [2:0] pprot,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_done,
  input wire logic memory_management_fault,
  input wire logic acc_execute_never,
  input wire logic acc_strongly_ordered
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence scs_s;
    acc_valid && ((acc_addr & SCS_MASK) == SCS_BASE);
  endsequence
  chk_ready_follow: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_unpriv_err: assert property (setup_s ##0 !pprot[0] |=> pslverr && prdata == 32'h0)
    else $error("unprivileged access not refused");
  chk_done_lat: assert property (acc_valid |=> acc_done)
    else $error("check answer missing");
  chk_done_idle: assert property (!acc_valid |=> !acc_done)
    else $error("check answer without request");
  chk_fault_done: assert property (memory_management_fault |-> acc_done)
    else $error("fault outside answer");
  chk_scs_attr: assert property (scs_s |=> acc_execute_never && acc_strongly_ordered)
    else $error("control space attributes wrong");
  chk_scs_allow: assert property (scs_s |=> !memory_management_fault)
    else $error("control space access faulted");
  chk_vtab_allow: assert property (acc_valid && acc_addr < VTAB_LIMIT |=> !memory_management_fault)
    else $error("vector table access faulted");
endmodule
bind rpc_top rpc_top_props u_props (.*);

/* tb/rpc_top_tb.sv */
// self-checking bench for rpc_top: apb master plus core model
// assumes one-cycle apb answer and one-cycle check answer
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("unexpected at %0t got %h want %h", $time, a, b); end end
module rpc_top_tb
  import rpc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, acc_addr;
  logic [2:0] pprot;
  logic acc_valid, acc_priv, acc_write, acc_fetch, acc_high_prio, acc_done;
  logic memory_management_fault, acc_execute_never, acc_strongly_ordered;
  int error_cnt = 0;
  int checks_done = 0;
  rpc_top #(.REGIONS(NUM_REGIONS)) DUT (.*);
  rpc_core_model core (.*);
  always #4 pclk = ~pclk;
  ////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [31:0] a, d, input logic pr,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= {2'b00, pr};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 1'b1, r, e);
  endtask
  task automatic rd(input logic [31:0] a, x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, 1'b1, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask
  task automatic acc_wf(input logic [31:0] c, a, input logic p, h, w, fe, xf);
    logic f, x, s;
    wr(ADDR_CTRL, c);
    core.issue(a, p, h, w, fe, f, x, s);
    `CHK(f, xf)
    `CHK(x, (a & SCS_MASK) == SCS_BASE)
    `CHK(s, (a & SCS_MASK) == SCS_BASE)
  endtask
  task automatic acc(input logic [31:0] c, a, input logic p, h, xf);
    acc_wf(c, a, p, h, 1'b0, 1'b0, xf);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(ADDR_CAPS, 32'h00000800, 1'b0);
    for (int i = 1; i < 11; i++) rd(32'(ADDR_CAPS + 4 * i), 32'h0, 1'b0);
  endtask
  task automatic t_refuse;
    logic [31:0] r;
    logic e;
    apb(1'b1, ADDR_CTRL, 32'h1, 1'b0, r, e);
    `CHK(e, 1'b1)
    rd(ADDR_CTRL, 32'h0, 1'b0);
    rd(32'hE000EDBC, 32'h0, 1'b1);
  endtask
  task automatic t_select;
    wr(ADDR_SEL, 32'h3);
    wr(ADDR_BASE, 32'h20000005);
    rd(ADDR_SEL, 32'h3, 1'b0);
    rd(ADDR_BASE, 32'h20000003, 1'b0);
    wr(ADDR_BASE_A1, 32'h30000016);
    rd(ADDR_SEL, 32'h6, 1'b0);
    rd(ADDR_BASE_A2, 32'h30000006, 1'b0);
    wr(ADDR_ATTR_A3, 32'hFFFFFFFF);
    rd(ADDR_ATTR, ATTR_WMASK, 1'b0);
  endtask
  task automatic t_check;
    wr(ADDR_ATTR, 32'h03000013);
    wr(ADDR_BASE, 32'h30000017);
    wr(ADDR_ATTR, 32'h00000009);
    acc(32'h0, 32'h40000000, 1'b0, 1'b0, 1'b0);
    acc(32'h4, 32'h30000000, 1'b0, 1'b0, 1'b0);
    acc(32'h1, 32'h40000000, 1'b1, 1'b0, 1'b1);
    acc(32'h1, 32'h300003FC, 1'b0, 1'b0, 1'b0);
    acc(32'h1, 32'h30000400, 1'b0, 1'b0, 1'b1);
    acc(32'h1, 32'h30000010, 1'b0, 1'b0, 1'b1);
    acc(32'h1, 32'hE000ED00, 1'b0, 1'b0, 1'b0);
    acc(32'h1, 32'h00000100, 1'b0, 1'b0, 1'b0);
    acc(32'h5, 32'h40000000, 1'b1, 1'b0, 1'b0);
    acc(32'h5, 32'h30000000, 1'b1, 1'b0, 1'b1);
    acc(32'h5, 32'h40000000, 1'b0, 1'b0, 1'b1);
    acc(32'h1, 32'h40000000, 1'b1, 1'b1, 1'b0);
    acc(32'h3, 32'h40000000, 1'b1, 1'b1, 1'b1);
    acc(32'h0, 32'hE000E100, 1'b1, 1'b0, 1'b0);
    wr(ADDR_SEL, 32'h5);
    wr(ADDR_ATTR, 32'h0300003F);
    acc(32'h1, 32'hC0000000, 1'b0, 1'b0, 1'b0);
    wr(ADDR_ATTR, 32'h1200003F);
    acc_wf(32'h1, 32'hC0000000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    acc_wf(32'h1, 32'hC0000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    acc_wf(32'h1, 32'hC0000000, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    acc_wf(32'h1, 32'hC0000000, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    acc_wf(32'h1, 32'hE000ED00, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite} = 5'h00;
    {paddr, pwdata, pprot} = 67'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_refuse();
    t_select();
    t_check();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0, 1'b0);
    wrap_up();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    wrap_up();
  end
endmodule
